// *** design/adc_conversion_control.sv ***
// Register file and sequencer that drive the analog converter core.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Analog core control
   output logic regulator_enable,
   output logic regulator_force_zero,
   output logic converter_enable,
   output logic converter_reset,
   output logic converter_clock_select,
   output logic single_ended_select,
   output logic midscale_mute,
   output logic [3:0] mux_source,
   output logic mux_valid,
   output logic input_sign_invert,
   output logic sample_start,
   // Analog core answer
   input wire logic sample_ready,
   input wire logic [RES_W-1:0] sample_data,
   // Interrupt toward interrupt_controller_unit
   output logic conversion_irq
);

   // ---------------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [31:0] base);
      hit = (a == base);
   endfunction

   logic wr_ctrl;
   logic wr_clear;
   assign wr_ctrl = wr && hit(addr, CTRL_ADDR);
   assign wr_clear = wr && hit(addr, CLEAR_ADDR);

   // ---------------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic start_reg;
   logic done_reg;
   logic complete;
   conv_state_e state_reg;
   conv_state_e state_next;

   // The done bit is not stored here and bit 2 stays zero; bit 1 is stored but reads back as start_reg.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= wdata & CTRL_WR_MASK;
      end
   end

   logic en;
   assign en = ctrl_reg[BIT_EN];

   // A start written with the enable bit clear is dropped, the core is held in reset.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         start_reg <= 1'b0;
      end else if (wr_ctrl ? !wdata[BIT_EN] : !en) begin
         start_reg <= 1'b0;
      end else if (complete) begin
         start_reg <= 1'b0;
      end else if (wr_ctrl && wdata[BIT_START]) begin
         start_reg <= 1'b1;
      end
   end

   // Completion wins over a clear written in the same cycle.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_reg <= 1'b0;
      end else if (complete) begin
         done_reg <= 1'b1;
      end else if (wr_clear) begin
         done_reg <= 1'b0;
      end
   end

   assign conversion_irq = done_reg && ctrl_reg[BIT_UNMASK];

   // ---------------------------------------------------------------------
   // Conversion sequencer
   // ---------------------------------------------------------------------
   logic chop;
   logic second;
   logic [CNT_W-1:0] cnt_reg;
   logic [RES_W:0] acc_reg;
   logic [RES_W-1:0] final_value;
   logic [RES_W-1:0] adj_sample;

   assign chop = ctrl_reg[BIT_CHOP];
   assign second = (state_reg == ST_SAMPLE2) || (state_reg == ST_WAIT2);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_reg && en) begin
               state_next = ST_SAMPLE1;
            end
         end
         ST_SAMPLE1: begin
            state_next = ST_WAIT1;
         end
         ST_WAIT1: begin
            if (sample_ready) begin
               state_next = chop ? ST_SAMPLE2 : ST_IDLE;
            end
         end
         ST_SAMPLE2: begin
            state_next = ST_WAIT2;
         end
         ST_WAIT2: begin
            if (sample_ready) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst || !en) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Count loaded with CONV_CYC on entry to each sample state; the sequencer does not wait on it.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (state_next == ST_SAMPLE1 || state_next == ST_SAMPLE2) begin
         cnt_reg <= CNT_W'(CONV_CYC);
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign sample_start = (state_reg == ST_SAMPLE1)
                         || (state_reg == ST_SAMPLE2);

   // The sign at the core output is undone here so both halves agree.
   logic cur_sign;
   assign cur_sign = ctrl_reg[BIT_SIGN] ^ second;
   assign adj_sample = cur_sign ? ~sample_data : sample_data;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         acc_reg <= '0;
      end else if (state_reg == ST_WAIT1 && sample_ready) begin
         acc_reg <= {1'b0, adj_sample};
      end
   end

   // Averaging two halves trades one LSB of headroom for offset removal.
   logic [RES_W:0] sum;
   assign sum = acc_reg + {1'b0, adj_sample};
   assign final_value = (state_reg == ST_WAIT2) ? sum[RES_W:1]
                                                : adj_sample;

   assign complete = sample_ready && ((state_reg == ST_WAIT1 && !chop)
                     || state_reg == ST_WAIT2);

   logic [RES_W-1:0] result;
   result_store u_result (
      .clk(clk),
      .nrst(nrst),
      .wr_en(complete),
      .wr_data(final_value),
      .rd_data(result)
   );

   // ---------------------------------------------------------------------
   // Analog controls
   // ---------------------------------------------------------------------
   assign regulator_enable = ctrl_reg[BIT_LDO_EN];
   assign regulator_force_zero = ctrl_reg[BIT_LDO_ZERO];
   assign converter_enable = en;
   assign converter_reset = !en;
   assign converter_clock_select = ctrl_reg[BIT_CLKSEL];
   assign single_ended_select = ctrl_reg[BIT_SE];
   assign midscale_mute = ctrl_reg[BIT_MUTE];
   assign input_sign_invert = cur_sign;

   // Software must hold the select stable before start; it is not latched.
   logic [3:0] sel;
   assign sel = ctrl_reg[SEL_HI:SEL_LO];
   always_comb begin
      if (ctrl_reg[BIT_SE]) begin
         mux_source = sel;
         mux_valid = (sel <= SRC_RAIL_LAST);
      end else begin
         mux_source = (sel == 4'h0) ? DIFF_PAIR01 : DIFF_PAIR23;
         mux_valid = 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------------
   logic [15:0] ctrl_view;
   always_comb begin
      ctrl_view = ctrl_reg;
      ctrl_view[BIT_DONE] = done_reg;
      ctrl_view[BIT_START] = start_reg;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (rd && hit(addr, CTRL_ADDR)) begin
         rdata <= ctrl_view;
      end else if (rd && hit(addr, RESULT_ADDR)) begin
         rdata <= {6'h00, result};
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule

// *** design/result_store.sv ***
// Result holding register for the last conversion value.
`timescale 1ns/1ps
module result_store
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Write side
   input wire logic wr_en,
   input wire logic [RES_W-1:0] wr_data,
   // Read side
   output logic [RES_W-1:0] rd_data
);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_data <= '0;
      end else if (wr_en) begin
         rd_data <= wr_data;
      end
   end

endmodule

// *** pkg/adc_ctrl_pkg.sv ***
// Constants and types shared by the converter control block.
package adc_ctrl_pkg;

   // ---------------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam logic [31:0] CTRL_ADDR = 32'h5000_1500;
   localparam logic [31:0] CLEAR_ADDR = 32'h5000_1508;
   localparam logic [31:0] RESULT_ADDR = 32'h5000_150A;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WR_MASK = 16'hFFEB;

   // ---------------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------------
   localparam int BIT_LDO_ZERO = 15;
   localparam int BIT_LDO_EN = 14;
   localparam int BIT_CHOP = 13;
   localparam int BIT_MUTE = 12;
   localparam int BIT_SE = 11;
   localparam int BIT_SIGN = 10;
   localparam int SEL_HI = 9;
   localparam int SEL_LO = 6;
   localparam int BIT_UNMASK = 5;
   localparam int BIT_DONE = 4;
   localparam int BIT_CLKSEL = 3;
   localparam int BIT_START = 1;
   localparam int BIT_EN = 0;

   localparam int RES_W = 10;
   localparam logic [RES_W-1:0] MIDSCALE = 10'h200;

   // Source codes toward the analog multiplexer.
   localparam logic [3:0] SRC_RAIL_LAST = 4'h9;
   localparam logic [3:0] DIFF_PAIR01 = 4'h0;
   localparam logic [3:0] DIFF_PAIR23 = 4'h1;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SAMPLE1, ST_WAIT1, ST_SAMPLE2, ST_WAIT2
   } conv_state_e;

endpackage

// *** test/adc_ctrl_properties.sv ***
// Port checks for the converter control block.
`timescale 1ns/1ps
module adc_ctrl_properties
   import adc_ctrl_pkg::*;
(
   // Clock, reset and register port
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   // Core side
   input wire logic regulator_enable,
   input wire logic regulator_force_zero,
   input wire logic converter_enable,
   input wire logic converter_reset,
   input wire logic converter_clock_select,
   input wire logic single_ended_select,
   input wire logic midscale_mute,
   input wire logic [3:0] mux_source,
   input wire logic mux_valid,
   input wire logic sample_start,
   input wire logic sample_ready,
   input wire logic conversion_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ---------------------------------------------------------------
   // Steps
   // ---------------------------------------------------------------
   sequence ctrl_wr;
      wr && addr == CTRL_ADDR;
   endsequence
   sequence start_wr;
      ctrl_wr ##0 (wdata[1:0] == 2'b11) ##0 !sample_start;
   endsequence
   a_regulator_bits: assert property (ctrl_wr |=>
      regulator_enable == $past(wdata[14]) &&
      regulator_force_zero == $past(wdata[15])) else $error("ldo bits");
   a_mode_bits: assert property (ctrl_wr |=>
      converter_clock_select == $past(wdata[3]) &&
      single_ended_select == $past(wdata[11]) &&
      midscale_mute == $past(wdata[12])) else $error("mode bits");
   a_enable_reset: assert property (ctrl_wr |=>
      converter_enable == $past(wdata[0]) &&
      converter_reset == !$past(wdata[0])) else $error("enable");
   a_diff_pair: assert property (ctrl_wr ##0 !wdata[11] |=>
      mux_source == (($past(wdata[9:6]) == 4'h0) ? DIFF_PAIR01
      : DIFF_PAIR23)) else $error("diff pair");
   a_se_source: assert property (ctrl_wr ##0 wdata[11] |=>
      mux_source == $past(wdata[9:6]) &&
      mux_valid == ($past(wdata[9:6]) <= SRC_RAIL_LAST))
      else $error("se source");
   a_irq_masked: assert property (ctrl_wr ##0 !wdata[5] |=>
      !conversion_irq) else $error("irq not masked");
   // A completion on the same edge wins, so a ready pulse is excluded.
   a_clear_drops: assert property (wr && addr == CLEAR_ADDR &&
      !sample_ready |=> !conversion_irq) else $error("clear");
   a_start_launch: assert property (start_wr |-> ##2 sample_start)
      else $error("no sample start");
   a_start_single: assert property (sample_start |=>
      !sample_start) else $error("start pulse long");
   a_clear_reads_zero: assert property (rd && addr == CLEAR_ADDR
      |=> rdata == 16'h0000) else $error("clear read");
   a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
      else $error("rdata not idle");
endmodule
bind adc_conversion_control adc_ctrl_properties chk_u (.clk, .nrst,
   .addr, .wdata, .wr, .rd, .rdata, .regulator_enable,
   .regulator_force_zero, .converter_enable, .converter_reset,
   .converter_clock_select, .single_ended_select, .midscale_mute,
   .mux_source, .mux_valid, .sample_start, .sample_ready,
   .conversion_irq);

// *** test/analog_core_model.sv ***
// Behavioural model of the analog converter core.
`timescale 1ns/1ps
module analog_core_model
   import adc_ctrl_pkg::*;
(
   // Clock, reset and control
   input wire logic clk,
   input wire logic nrst,
   input wire logic sample_start,
   input wire logic converter_reset,
   input wire logic input_sign_invert,
   input wire logic midscale_mute,
   // Analog level and answer delay
   input wire logic [RES_W-1:0] level,
   input wire logic [3:0] lag,
   // Answer
   output logic sample_ready,
   output logic [RES_W-1:0] sample_data
);
   localparam logic [RES_W-1:0] OFFV = 10'h004;
   logic busy;
   logic [3:0] cnt;
   logic [RES_W-1:0] raw;
   assign raw = midscale_mute ? MIDSCALE : level;
   // The offset makes only a chopped pair return the bare level.
   always @(posedge clk) begin
      sample_ready <= 1'b0;
      sample_data <= ~sample_data;
      if (!nrst || converter_reset) begin
         busy <= 1'b0;
         sample_data <= 10'h000;
      end else if (sample_start) begin
         busy <= 1'b1;
         cnt <= lag;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         busy <= 1'b0;
         sample_ready <= 1'b1;
         sample_data <= input_sign_invert ? ~(raw - OFFV)
            : raw + OFFV;
      end
   end
endmodule

// *** test/tb_adc_conversion_control.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb_adc_conversion_control
   import adc_ctrl_pkg::*;
   ;
   typedef struct {logic [15:0] c; logic [9:0] l; logic [9:0] r;} row_s;
   logic clk, nrst, wr, rd, converter_reset, input_sign_invert;
   logic midscale_mute, sample_start, sample_ready, conversion_irq;
   logic [ADDR_W-1:0] addr;
   logic [15:0] wdata, rdata, d;
   logic [9:0] level, sample_data;
   logic [3:0] lag;
   int errors = 0;
   int num_checks = 0;
   int n;
   row_s rows [6] = '{'{16'h48A0, 10'h123, 10'h127},
      '{16'h4CA0, 10'h123, 10'h11F}, '{16'h68A0, 10'h123, 10'h123},
      '{16'h58A0, 10'h123, 10'h204}, '{16'h2428, 10'h3F0, 10'h3F0},
      '{16'h4AE0, 10'h001, 10'h005}};
   adc_conversion_control dut_u (.clk, .nrst, .addr, .wdata, .wr, .rd,
      .rdata, .regulator_enable(), .regulator_force_zero(),
      .converter_enable(), .converter_reset, .converter_clock_select(),
      .single_ended_select(), .midscale_mute, .mux_source(),
      .mux_valid(), .input_sign_invert, .sample_start, .sample_ready,
      .sample_data, .conversion_irq);
   analog_core_model core_u (.clk, .nrst, .sample_start,
      .converter_reset, .input_sign_invert, .midscale_mute, .level,
      .lag, .sample_ready, .sample_data);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input string s, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [15:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [31:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial begin
      nrst = 1'b0;
      {wr, rd, addr, wdata, level, lag} = '0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(CTRL_ADDR);
      chk("ctrl reset", CTRL_RESET, d);
      foreach (rows[i]) begin
         level <= rows[i].l;
         lag <= 4'(i * 3);
         wr_reg(CTRL_ADDR, rows[i].c | 16'h0001);
         wr_reg(CTRL_ADDR, rows[i].c | 16'h0003);
         n = 0;
         while (conversion_irq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         if (n >= 200) begin
            errors++;
            $display("CHECK FAILED row irq exp 1 got 0");
         end
         rd_reg(RESULT_ADDR);
         chk("result", {6'h00, rows[i].r}, d);
         rd_reg(CTRL_ADDR);
         chk("ctrl done", rows[i].c | 16'h0011, d);
         wr_reg(CLEAR_ADDR, 16'hFFFF);
         rd_reg(CTRL_ADDR);
         chk("ctrl clear", rows[i].c | 16'h0001, d);
      end
      wr_reg(CTRL_ADDR, 16'h4803);
      n = 0;
      do begin
         rd_reg(CTRL_ADDR);
         n++;
      end while (d[BIT_DONE] !== 1'b1 && n < 50);
      chk("masked flag", 16'h4811, d);
      chk("masked irq", 16'h0000, {15'h0, conversion_irq});
      wr_reg(CTRL_ADDR, 16'h4821);
      @(posedge clk);
      chk("unmasked irq", 16'h0001, {15'h0, conversion_irq});
      wr_reg(CLEAR_ADDR, 16'h0000);
      rd_reg(CLEAR_ADDR);
      chk("clear read", 16'h0000, d);
      chk("irq cleared", 16'h0000, {15'h0, conversion_irq});
      rd_reg(CTRL_ADDR + 32'h20);
      chk("unmapped", 16'h0000, d);
      wr_reg(CTRL_ADDR, 16'h0002);
      rd_reg(CTRL_ADDR);
      chk("start off", 16'h0000, d);
      chk("core reset", 16'h0001, {15'h0, converter_reset});
      wr_reg(CTRL_ADDR, 16'hC801);
      wr_reg(CTRL_ADDR, 16'hC803);
      repeat (3) @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(CTRL_ADDR);
      chk("ctrl rerun", CTRL_RESET, d);
      rd_reg(RESULT_ADDR);
      chk("result rerun", 16'h0000, d);
      wrap_up();
   end
endmodule
